// ### rtl/sfe_params.svh
// Constants for the fault latch and serial link checker
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH
`define SFE_CLK_KHZ 40000
`define SFE_STRETCH_MS 200
`define SFE_WD_LONG_MS 1200
`define SFE_WD_MID_MS 600
`define SFE_WD_SHORT_MS 200
`define SFE_OC_PULSE_US 100
`define SFE_OC_PULSE_CYC 12'((`SFE_OC_PULSE_US * `SFE_CLK_KHZ) / 1000)
`define SFE_CRC_POLY 7'h37
`define SFE_CRC_SEED 7'h7F
`define SFE_Z_BIT 15
`define SFE_CFG_SCOFF 4
`define SFE_WD_OFF 2'h3
`define SFE_REG_RST 8'h00
`define SFE_SYNC_RST 41'h1
`define SFE_G_WD 7
`define SFE_G_CRC 6
`define SFE_G_DCDC 5
`define SFE_G_CK 4
`define SFE_G_DIE 3
`define SFE_G_V5 2
`define SFE_G_VDD 1
`define SFE_G_WARN 0
`endif

// ### rtl/sfe_pkg.sv
// Types for the fault latch and serial link checker
package sfe_pkg;
  typedef enum logic [6:0] {
    SFE_CMD_SET_OUT = 7'h00,
    SFE_CMD_SET_PP  = 7'h01,
    SFE_CMD_SET_OL  = 7'h02,
    SFE_CMD_SET_CFG = 7'h03,
    SFE_CMD_READ    = 7'h20,
    SFE_CMD_STATUS  = 7'h30
  } sfe_cmd_t;
  typedef logic [7:0] sfe_byte_t;
endpackage

// ### rtl/sfe_fault_check.sv
// Fault latching, frame checking and watchdog for an eight-channel driver
`include "sfe_params.svh"

// How it works
// - Per-channel fault bit on SDO is thermal OR open-load.
// - Latched fault bits set at once on events, held until cleared.
// - Fault-clear bit clears all latched registers at chip-select rise.
// - Clear is skipped when the frame had a CRC or clock-count error.
// - Serial plus command mode: clear bit also releases the latched fault pin.
// - Read command returns latched value plus real-time values, stretched only for thermal, open-load and die.
// - Parallel mode: output-state writes stored but outputs follow input pins.
// - Channel overtemperature kills that channel's drivers and sets its thermal bit.
// - Die overtemperature kills all drivers and sets global bit 3.
// - Open-load counts only in high-side mode with detection enabled.
// - Supply or 5V undervoltage kills drivers and LEDs, sets bit 1 or 2.
// - No chip-select fall within timeout sets watchdog flag until next fall.
// - Clock count not a multiple of 8 discards data, flags, pulls fault low.
// - Check mismatch discards data, keeps state, sets global bit 6.
// - Overcurrent sets slow mode and pulses fault low; register 7 reads zero, its real-time byte shows raw overcurrent.
// - Thermal signal held at least 200ms inside logic; drivers use raw.
// - Serial plus command mode: fault pin is latched; otherwise it shows real-time faults.
// - Checking active only in serial mode with check-enable input high.
// - Seven-bit check, generator x7+x5+x4+x2+x+1, seed all ones.
// - Inbound check covers 16 data bits plus the trailing one bit after them; first bit MSB.
// - Output and configuration updates applied only when the check matches.
// - Error feedback bit reports the previous frame's reception.
// - Outbound check covers response word plus error feedback bit.
module sfe_fault_check #(
  parameter int STRETCH_CYC  = `SFE_STRETCH_MS * `SFE_CLK_KHZ,
  parameter int WD_LONG_CYC  = `SFE_WD_LONG_MS * `SFE_CLK_KHZ,
  parameter int WD_MID_CYC   = `SFE_WD_MID_MS * `SFE_CLK_KHZ,
  parameter int WD_SHORT_CYC = `SFE_WD_SHORT_MS * `SFE_CLK_KHZ
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  input  wire logic       serial_setting_select,
  input  wire logic       command_mode_select,
  input  wire logic       check_enable_input,
  input  wire logic [7:0] in_pins,
  input  wire logic [7:0] channel_overtemp_raw,
  input  wire logic [7:0] open_load_raw,
  input  wire logic [7:0] overcurrent_raw,
  input  wire logic       die_overtemp_raw,
  input  wire logic       vdd_uvlo_raw,
  input  wire logic       v5_uvlo_raw,
  input  wire logic       vdd_warn_raw,
  input  wire logic       dcdc_ilim_raw,
  output logic [7:0]      hs_on,
  output logic [7:0]      ls_on,
  output logic [7:0]      led_fault,
  output logic [7:0]      led_status,
  output logic [7:0]      slow_mode,
  output logic [7:0]      channel_overtemp_flag,
  output logic [7:0]      open_load_flag,
  output logic [7:0]      global_fault_flags,
  output logic            watchdog_timeout_flag,
  output logic            clock_count_error_flag,
  output logic            crc_error_feedback_bit,
  output logic            fault_n
);
  localparam int STW = $clog2(STRETCH_CYC + 1);
  localparam int WDW = $clog2(WD_LONG_CYC + 1);

  // Serial check over 17 bits, first bit shifted in first
  // generator and seed
  function automatic logic [6:0] crc17(input logic [16:0] bits);
    logic [6:0] c;
    logic       fb;
    c = `SFE_CRC_SEED;
    for (int i = 16; i >= 0; i--)
    begin
      fb = bits[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? `SFE_CRC_POLY : 7'h00);
    end
    return c;
  endfunction

  // Link side: shift and count on sck
  logic [23:0] rx_sh_reg;
  logic [7:0]  bit_cnt_reg;
  logic [4:0]  tx_idx_reg;
  logic [23:0] tx_word_reg;
  wire  [4:0]  tx_pos = 5'h17 - tx_idx_reg;

  always_ff @(posedge sck)
  begin
    rx_sh_reg <= {rx_sh_reg[22:0], sdi};
  end

  // Sck stands still at reset, so the count clears asynchronously
  always_ff @(posedge sck or posedge reset)
  begin
    if (reset)
      bit_cnt_reg <= 8'h00;
    else
      bit_cnt_reg <= bit_cnt_reg + 8'h01;
  end

  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
      tx_idx_reg <= 5'h00;
    else if (tx_idx_reg != 5'h1F)
      tx_idx_reg <= tx_idx_reg + 5'h01;
  end

  assign sdo = !cs_n && (tx_idx_reg <= 5'h17) && tx_word_reg[tx_pos];

  // Pin synchronisers
  logic [40:0] meta_reg;
  logic [40:0] sync_reg;
  wire  [40:0] async_in = {in_pins, channel_overtemp_raw, open_load_raw, overcurrent_raw,
                           die_overtemp_raw, vdd_uvlo_raw, v5_uvlo_raw, vdd_warn_raw,
                           dcdc_ilim_raw, serial_setting_select, command_mode_select,
                           check_enable_input, cs_n};
  wire  [7:0]  in_s;
  wire  [7:0]  th_s;
  wire  [7:0]  ol_s;
  wire  [7:0]  oc_s;
  wire         die_s;
  wire         vdd_s;
  wire         v5_s;
  wire         warn_s;
  wire         dcdc_s;
  wire         ser_s;
  wire         cmd_s;
  wire         chk_s;
  wire         cs_s;
  assign {in_s, th_s, ol_s, oc_s, die_s, vdd_s, v5_s, warn_s, dcdc_s, ser_s, cmd_s, chk_s, cs_s} = sync_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= `SFE_SYNC_RST;
      sync_reg <= `SFE_SYNC_RST;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // Frame boundaries and checks; link data is quiet while cs_n is high
  logic        cs_d_reg;
  logic [7:0]  cnt_prev_reg;
  logic [7:0]  out_reg;
  logic [7:0]  pp_reg;
  logic [7:0]  olen_reg;
  logic [7:0]  cfg_reg;
  wire         frame_end = cs_s && !cs_d_reg;
  wire         frame_start = !cs_s && cs_d_reg;
  wire  [7:0]  nbits = bit_cnt_reg - cnt_prev_reg;
  wire         ck_bad = nbits[2:0] != 3'h0;
  wire         crc_on = ser_s && chk_s;
  wire  [15:0] rx_word = crc_on ? rx_sh_reg[23:8] : rx_sh_reg[15:0];
  wire  [6:0]  rx_fcs = crc17({rx_sh_reg[23:8], rx_sh_reg[7]});
  wire         crc_bad = crc_on && (rx_fcs != rx_sh_reg[6:0]);
  wire         good = frame_end && !ck_bad && !crc_bad;
  wire  [6:0]  cmd_w = rx_word[14:8];
  wire         fclr = good && rx_word[`SFE_Z_BIT];
  wire         rd = good && (cmd_w == sfe_pkg::SFE_CMD_READ);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_d_reg <= 1'b1;
      cnt_prev_reg <= 8'h00;
    end
    else
    begin
      cs_d_reg <= cs_s;
      if (frame_end)
        cnt_prev_reg <= bit_cnt_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_reg <= `SFE_REG_RST;
      pp_reg <= `SFE_REG_RST;
      olen_reg <= `SFE_REG_RST;
      cfg_reg <= `SFE_REG_RST;
    end
    else if (good)
    begin
      if (cmd_w == sfe_pkg::SFE_CMD_SET_OUT)
        out_reg <= rx_word[7:0];
      if (cmd_w == sfe_pkg::SFE_CMD_SET_PP)
        pp_reg <= rx_word[7:0];
      if (cmd_w == sfe_pkg::SFE_CMD_SET_OL)
        olen_reg <= rx_word[7:0];
      if (cmd_w == sfe_pkg::SFE_CMD_SET_CFG)
        cfg_reg <= rx_word[7:0];
    end
  end

  // Stretch of thermal, open-load and die signals
  // open-load gated by mode and enable
  wire  [7:0]  ol_evt = ol_s & ~pp_reg & olen_reg;
  wire  [16:0] st_raw = {die_s, ol_evt, th_s};
  wire  [16:0] st_out;
  wire  [7:0]  th_st = st_out[7:0];
  wire  [7:0]  ol_st = st_out[15:8];
  wire         die_st = st_out[16];
  genvar g;
  generate
    for (g = 0; g < 17; g++)
    begin : g_st
      logic [STW-1:0] cnt_reg;
      // hold at least the stretch time
      always_ff @(posedge clk)
      begin
        if (reset)
          cnt_reg <= '0;
        else if (st_raw[g])
          cnt_reg <= STW'(STRETCH_CYC);
        else if (cnt_reg != '0)
          cnt_reg <= cnt_reg - STW'(1);
      end
      assign st_out[g] = st_raw[g] || (cnt_reg != '0);
    end
  endgenerate

  // Watchdog on chip-select falls
  logic [WDW-1:0] wd_cnt_reg;
  logic           wd_flag_reg;
  logic           crc_flag_reg;
  logic           ck_flag_reg;
  wire            wd_en = cfg_reg[1:0] != `SFE_WD_OFF;
  wire [WDW-1:0]  wd_lim = (cfg_reg[1:0] == 2'h0) ? WDW'(WD_LONG_CYC) :
                           (cfg_reg[1:0] == 2'h1) ? WDW'(WD_MID_CYC) : WDW'(WD_SHORT_CYC);

  always_ff @(posedge clk)
  begin
    if (reset || frame_start)
    begin
      wd_cnt_reg <= '0;
      wd_flag_reg <= 1'b0;
    end
    else
    begin
      if (wd_cnt_reg < wd_lim)
        wd_cnt_reg <= wd_cnt_reg + WDW'(1);
      if (wd_en && wd_cnt_reg >= wd_lim)
        wd_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      crc_flag_reg <= 1'b0;
      ck_flag_reg <= 1'b0;
    end
    else if (frame_end)
    begin
      crc_flag_reg <= crc_bad;
      ck_flag_reg <= ck_bad;
    end
  end

  // Latched fault registers, set wins over clear
  logic [7:0] ol_lat;
  logic [7:0] th_lat;
  logic [7:0] glob_lat;
  logic [7:0] slow_reg;
  wire  [7:0] glob_evt;
  assign glob_evt[`SFE_G_WD] = wd_flag_reg;
  assign glob_evt[`SFE_G_CRC] = crc_flag_reg;
  assign glob_evt[`SFE_G_DCDC] = dcdc_s;
  assign glob_evt[`SFE_G_CK] = ck_flag_reg;
  assign glob_evt[`SFE_G_DIE] = die_s;
  assign glob_evt[`SFE_G_V5] = v5_s;
  assign glob_evt[`SFE_G_VDD] = vdd_s;
  assign glob_evt[`SFE_G_WARN] = warn_s;
  wire  [7:0] keep = fclr ? 8'h00 : 8'hFF;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ol_lat <= 8'h00;
      th_lat <= 8'h00;
      glob_lat <= 8'h00;
      slow_reg <= 8'h00;
    end
    else
    begin
      ol_lat <= (ol_lat & keep) | ol_evt;
      th_lat <= (th_lat & keep) | th_s;
      glob_lat <= (glob_lat & keep) | glob_evt;
      slow_reg <= (slow_reg & keep) | oc_s;
    end
  end

  // Read selection and response word
  wire  [7:0] glob_rt = {glob_evt[7:4], die_st, glob_evt[2:0]};
  wire  [7:0] q_arr [8];
  wire  [7:0] a_arr [4];
  wire  [2:0] sel = rx_word[2:0];
  assign q_arr[0] = out_reg;
  assign q_arr[1] = pp_reg;
  assign q_arr[2] = olen_reg;
  assign q_arr[3] = cfg_reg;
  assign q_arr[4] = ol_lat;
  assign q_arr[5] = th_lat;
  assign q_arr[6] = glob_lat;
  assign q_arr[7] = 8'h00;
  assign a_arr[0] = ol_st;
  assign a_arr[1] = th_st;
  assign a_arr[2] = glob_rt;
  assign a_arr[3] = oc_s;
  wire  [7:0]  a_sel = sel[2] ? a_arr[sel[1:0]] : 8'h00;
  wire  [7:0]  lvl_eff = ser_s ? out_reg : in_s;
  wire  [7:0]  f_rt = th_st | ol_st;
  wire  [15:0] resp = rd ? {a_sel, q_arr[sel]} : {f_rt, lvl_eff};
  // feedback of this reception goes out next frame
  // outbound check over response and feedback
  wire  [23:0] tx_next = crc_on ? {resp, crc_bad, crc17({resp, crc_bad})} : {resp, 8'h00};

  always_ff @(posedge clk)
  begin
    if (reset)
      tx_word_reg <= 24'h000000;
    else if (frame_end)
      tx_word_reg <= tx_next;
  end

  // Drivers, LEDs and fault pin
  logic [7:0]  hs_on_reg;
  logic [7:0]  ls_on_reg;
  logic [7:0]  led_fault_reg;
  logic [7:0]  led_status_reg;
  logic [7:0]  oc_d_reg;
  logic [11:0] oc_cnt_reg;
  logic        irq_reg;
  logic        fault_n_reg;
  wire         uv = vdd_s || v5_s;
  wire         kill_all = die_s || uv;
  wire  [7:0]  alive = ~th_s & {8{!kill_all}};
  wire         oc_rise = |(oc_s & ~oc_d_reg);
  wire         oc_pulse = oc_cnt_reg != 12'h000;
  wire         rt_any = |f_rt || die_st;
  wire         lm = ser_s && cmd_s;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hs_on_reg <= 8'h00;
      ls_on_reg <= 8'h00;
      led_fault_reg <= 8'h00;
      led_status_reg <= 8'h00;
    end
    else
    begin
      hs_on_reg <= lvl_eff & alive;
      ls_on_reg <= pp_reg & ~lvl_eff & alive;
      led_fault_reg <= uv ? 8'h00 : f_rt;
      led_status_reg <= uv ? 8'h00 : lvl_eff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      oc_d_reg <= 8'h00;
      oc_cnt_reg <= 12'h000;
    end
    else
    begin
      oc_d_reg <= oc_s;
      if (oc_rise && !cfg_reg[`SFE_CFG_SCOFF])
        oc_cnt_reg <= `SFE_OC_PULSE_CYC;
      else if (oc_pulse)
        oc_cnt_reg <= oc_cnt_reg - 12'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_reg <= 1'b0;
      fault_n_reg <= 1'b1;
    end
    else
    begin
      irq_reg <= (irq_reg && !(fclr && lm)) || rt_any;
      fault_n_reg <= !((lm ? irq_reg : rt_any) || ck_flag_reg || oc_pulse);
    end
  end

  assign hs_on = hs_on_reg;
  assign ls_on = ls_on_reg;
  assign led_fault = led_fault_reg;
  assign led_status = led_status_reg;
  assign slow_mode = slow_reg;
  assign channel_overtemp_flag = th_lat;
  assign open_load_flag = ol_lat;
  assign global_fault_flags = glob_lat;
  assign watchdog_timeout_flag = wd_flag_reg;
  assign clock_count_error_flag = ck_flag_reg;
  assign crc_error_feedback_bit = crc_flag_reg;
  assign fault_n = fault_n_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  rt_fault_a: assert property (good && !rd |=> tx_word_reg[23:16] == $past(f_rt))
    else $error("channel fault bits not thermal or open-load");
  latch_hold_a: assert property (!fclr |=> (th_lat & $past(th_lat)) == $past(th_lat))
    else $error("latched thermal bit dropped without clear");
  clear_all_a: assert property (fclr && ol_evt == 8'h00 && th_s == 8'h00 |=> ol_lat == 8'h00 && th_lat == 8'h00)
    else $error("fault registers not cleared");
  keep_bad_a: assert property (frame_end && (ck_bad || crc_bad) |=> (ol_lat & $past(ol_lat)) == $past(ol_lat))
    else $error("bad frame cleared faults");
  irq_rel_a: assert property (fclr && lm && !rt_any |=> !irq_reg)
    else $error("latched fault pin not released");
  par_out_a: assert property (!ser_s && !kill_all && th_s == 8'h00 |=> hs_on_reg == $past(in_s))
    else $error("parallel outputs not following pins");
  ch_ot_a: assert property (th_s != 8'h00 |=> (hs_on_reg & $past(th_s)) == 8'h00 && (th_lat & $past(th_s)) == $past(th_s))
    else $error("channel overtemperature not handled");
  die_ot_a: assert property (die_s |=> hs_on_reg == 8'h00 && ls_on_reg == 8'h00 && glob_lat[`SFE_G_DIE])
    else $error("die overtemperature not handled");
  uvlo_a: assert property (uv |=> led_fault_reg == 8'h00 && led_status_reg == 8'h00 && hs_on_reg == 8'h00)
    else $error("undervoltage did not blank outputs");
  wd_fall_a: assert property (frame_start |=> !wd_flag_reg)
    else $error("watchdog flag survived chip-select fall");
  ck_err_a: assert property (frame_end && ck_bad |=> ck_flag_reg ##1 !fault_n_reg)
    else $error("clock-count error not flagged");
  crc_err_a: assert property (frame_end && crc_bad |=> $stable(out_reg) && $stable(cfg_reg) ##1 glob_lat[`SFE_G_CRC])
    else $error("check mismatch not handled");
  oc_pulse_a: assert property (oc_rise && !cfg_reg[`SFE_CFG_SCOFF] |=> ##1 !fault_n_reg [*8])
    else $error("overcurrent fault pulse missing");
  stretch_a: assert property ($fell(th_s[0]) |-> th_st[0] ##1 th_st[0])
    else $error("thermal signal not stretched");

  clear_c: cover property (fclr);
  crc_bad_c: cover property (frame_end && crc_bad);
  wd_hit_c: cover property ($rose(wd_flag_reg));
  read_c: cover property (rd && sel[2]);
endmodule

// ### verification/sfe_spi_ctrl.sv
// Behavioural SPI controller driving frames on the link
module sfe_spi_ctrl (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Word MSB first, check byte last
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    cs_n = 1'b0;
    sdi = w[n-1];
    #7.5;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b1;
      rx = {rx[22:0], sdo};
      #7.5;
      sck = 1'b0;
      if (i < n - 1)
        sdi = w[n-2-i];
      #7.5;
    end
    cs_n = 1'b1;
    // Released line shows the inverse
    sdi = ~sdi;
    #300;
  endtask
endmodule

// ### verification/sfe_fault_check_tb.sv
// Scenario bench for the fault latch and link checker
module sfe_fault_check_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset, sck, cs_n, sdi, sdo;
  logic        serial_setting_select, command_mode_select, check_enable_input;
  logic        die_overtemp_raw, vdd_uvlo_raw, v5_uvlo_raw, vdd_warn_raw, dcdc_ilim_raw;
  logic        watchdog_timeout_flag, clock_count_error_flag, crc_error_feedback_bit, fault_n;
  logic [7:0]  in_pins, channel_overtemp_raw, open_load_raw, overcurrent_raw;
  logic [7:0]  hs_on, ls_on, led_fault, led_status, slow_mode;
  logic [7:0]  channel_overtemp_flag, open_load_flag, global_fault_flags;
  logic [23:0] rx;
  int          bad_count, comparisons;

  sfe_fault_check #(
    .STRETCH_CYC (20),
    .WD_LONG_CYC (300),
    .WD_MID_CYC  (200),
    .WD_SHORT_CYC(100)
  ) i_sfe_fault_check (.*);
  sfe_spi_ctrl i_sfe_spi_ctrl (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  always #12.5 clk = ~clk;

  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [6:0] crc7(input logic [16:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h7F;
    for (int i = 16; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h37 : 7'h00);
    end
    return c;
  endfunction

  // Check covers word plus trailing one
  task automatic frame(input logic [15:0] w, input logic bad);
    logic [6:0] c;
    c = crc7({w, 1'b1}) ^ {6'h00, bad};
    @(posedge clk);
    #3;
    if (check_enable_input && serial_setting_select)
      i_sfe_spi_ctrl.xfer({w, 1'b1, c}, 24, rx);
    else
      i_sfe_spi_ctrl.xfer({8'h00, w}, 16, rx);
    tick(2);
  endtask

  task automatic t_crc;
    frame(16'h00A5, 1'b0);
    cmp("hs_on", 8'hA5, hs_on);
    frame(16'h005A, 1'b1);
    cmp("hs_on", 8'hA5, hs_on);
    cmp("global", 8'h40, global_fault_flags);
    cmp("crc_error_feedback_bit", 8'h01, {7'h00, crc_error_feedback_bit});
    frame(16'h3000, 1'b0);
    cmp("sdo f", 8'h00, rx[23:16]);
    cmp("sdo l", 8'hA5, rx[15:8]);
    cmp("sdo crc_error_feedback_bit", 8'h01, {7'h00, rx[7]});
    cmp("sdo crc", {1'b0, crc7({16'h00A5, 1'b1})}, {1'b0, rx[6:0]});
    frame(16'h3000, 1'b0);
    cmp("sdo crc_error_feedback_bit", 8'h00, {7'h00, rx[7]});
  endtask

  task automatic t_latch;
    @(posedge clk);
    channel_overtemp_raw <= 8'h01;
    tick(6);
    cmp("thermal", 8'h01, channel_overtemp_flag);
    cmp("hs_on", 8'hA4, hs_on);
    cmp("fault_n", 8'h00, {7'h00, fault_n});
    channel_overtemp_raw <= 8'h00;
    tick(40);
    cmp("thermal", 8'h01, channel_overtemp_flag);
    frame(16'hB000, 1'b1);
    cmp("thermal", 8'h01, channel_overtemp_flag);
    frame(16'hB000, 1'b0);
    cmp("thermal", 8'h00, channel_overtemp_flag);
    // Mismatch flag of the frame before still stands at the clear, and set wins
    cmp("global", 8'h40, global_fault_flags);
    cmp("fault_n", 8'h01, {7'h00, fault_n});
  endtask

  task automatic t_count;
    @(posedge clk);
    #3;
    i_sfe_spi_ctrl.xfer(24'h000FFF, 12, rx);
    tick(2);
    cmp("ck flag", 8'h01, {7'h00, clock_count_error_flag});
    cmp("fault_n", 8'h00, {7'h00, fault_n});
    cmp("global ck", 8'h10, global_fault_flags & 8'h10);
    cmp("hs_on", 8'hA5, hs_on);
    frame(16'hB000, 1'b0);
  endtask

  task automatic t_supply;
    @(posedge clk);
    die_overtemp_raw <= 1'b1;
    tick(6);
    cmp("hs_on", 8'h00, hs_on);
    cmp("global", 8'h08, global_fault_flags & 8'h0E);
    die_overtemp_raw <= 1'b0;
    vdd_uvlo_raw <= 1'b1;
    tick(6);
    cmp("hs_on", 8'h00, hs_on);
    cmp("led", 8'h00, led_status | led_fault);
    cmp("global", 8'h0A, global_fault_flags & 8'h0E);
    vdd_uvlo_raw <= 1'b0;
    v5_uvlo_raw <= 1'b1;
    tick(6);
    cmp("led", 8'h00, led_status | led_fault);
    cmp("global", 8'h0E, global_fault_flags & 8'h0E);
    v5_uvlo_raw <= 1'b0;
    tick(30);
    frame(16'hB000, 1'b0);
  endtask

  task automatic t_overcurrent;
    @(posedge clk);
    overcurrent_raw <= 8'h10;
    tick(8);
    cmp("slow", 8'h10, slow_mode);
    cmp("fault_n", 8'h00, {7'h00, fault_n});
    overcurrent_raw <= 8'h00;
    tick(4100);
    cmp("fault_n", 8'h01, {7'h00, fault_n});
    cmp("wd", 8'h01, {7'h00, watchdog_timeout_flag});
    cmp("global wd", 8'h80, global_fault_flags & 8'h80);
    frame(16'hB000, 1'b0);
    cmp("wd", 8'h00, {7'h00, watchdog_timeout_flag});
    cmp("slow", 8'h00, slow_mode);
  endtask

  task automatic t_read;
    frame(16'h02FF, 1'b0);
    frame(16'h0101, 1'b0);
    @(posedge clk);
    open_load_raw <= 8'h03;
    tick(6);
    cmp("open load", 8'h02, open_load_flag);
    open_load_raw <= 8'h00;
    // Raw gone before the read frame ends, so only the stretch keeps A set
    frame(16'h2004, 1'b0);
    frame(16'h3000, 1'b0);
    cmp("read q", 8'h02, rx[15:8]);
    cmp("read a", 8'h02, rx[23:16]);
    cmp("read crc_error_feedback_bit", 8'h00, {7'h00, rx[7]});
  endtask

  task automatic t_parallel;
    @(posedge clk);
    serial_setting_select <= 1'b0;
    in_pins <= 8'h3C;
    tick(6);
    frame(16'h00FF, 1'b0);
    cmp("hs_on", 8'h3C, hs_on);
    cmp("global crc", 8'h00, global_fault_flags & 8'h50);
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    serial_setting_select = 1'b1;
    command_mode_select = 1'b1;
    check_enable_input = 1'b1;
    {die_overtemp_raw, vdd_uvlo_raw, v5_uvlo_raw, vdd_warn_raw, dcdc_ilim_raw} = 5'h00;
    {in_pins, channel_overtemp_raw, open_load_raw, overcurrent_raw} = 32'h00000000;
    bad_count = 0;
    comparisons = 0;
    tick(16);
    reset <= 1'b0;
    tick(1);
    cmp("fault_n", 8'h01, {7'h00, fault_n});
    cmp("global", 8'h00, global_fault_flags);
    tick(3);
    t_crc;
    t_latch;
    t_count;
    t_supply;
    t_overcurrent;
    t_read;
    t_parallel;
    give_verdict;
  end

  initial
  begin
    tick(20000);
    bad_count++;
    give_verdict;
  end
endmodule
